/* anpr_pkg.sv */
// package of offsets, field positions and reset values for the negotiation register bank
package anpr_pkg;
	// register byte addresses, decoded per 16-bit halfword; data rides in the low lanes
	localparam logic [7:0] OFF_PARTNER = 8'h0a;
	localparam logic [7:0] OFF_EXPANSION = 8'h0c;
	localparam logic [7:0] OFF_NEXT_PAGE = 8'h0e;
	localparam logic [7:0] OFF_IRQ_STATUS = 8'h20;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h24;
	// partner ability field positions
	localparam int PA_NEXT_PAGE = 15;
	localparam int PA_ACK = 14;
	localparam int PA_REMOTE_FAULT = 13;
	localparam int PA_ASYM_PAUSE = 11;
	localparam int PA_PAUSE = 10;
	localparam int PA_TECH_HI = 9;
	localparam int PA_TECH_LO = 5;
	localparam int PA_SEL_HI = 4;
	// expansion field positions
	localparam int EX_LOC_ABLE = 6;
	localparam int EX_LOC = 5;
	localparam int EX_PD_FAULT = 4;
	localparam int EX_LP_NP = 3;
	localparam int EX_NP_CAPABLE = 2;
	localparam int EX_PAGE_RX = 1;
	localparam int EX_LP_AN = 0;
	// outgoing next page field positions
	localparam int NP_MORE = 15;
	localparam int NP_RSVD = 14;
	localparam int NP_MSG_PAGE = 13;
	localparam int NP_COMPLY = 12;
	localparam int NP_TOGGLE = 11;
	localparam int NP_CODE_HI = 10;
	// reset values
	localparam logic [15:0] PARTNER_RESET = 16'h0000;
	localparam logic [1:0] EX_LOC_RESET = 2'h3;
	localparam logic [15:0] NP_RESET = 16'h2001;
	localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
	// interrupt status bit positions
	localparam int IRQ_PAGE_RX = 0;
	localparam int IRQ_PD_FAULT = 1;
	localparam int IRQ_W = 2;
endpackage

/* anpr_np_if.sv */
// interface between the register bank and its next-page transmit sequencer
`timescale 1ns/1ps
interface anpr_np_if;
	logic page_sent; // remote took the current outgoing page
	logic gig_mode; // pages are 1000BASE-T next pages
	logic [15:0] np_reg; // outgoing register contents
	logic toggle; // toggle value held by the sequencer
	logic [15:0] tx_word; // word handed to the engine
	modport bank (input toggle, input tx_word, output page_sent, output gig_mode, output np_reg);
	modport seq (output toggle, output tx_word, input page_sent, input gig_mode, input np_reg);
endinterface

/* anpr_np_seq.sv */
// outgoing next-page word builder and toggle keeper
`timescale 1ns/1ps
module anpr_np_seq (
	input wire logic clk,
	input wire logic rst_n,
	anpr_np_if.seq np
);
	// toggle flips after each page the remote accepts
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			np.toggle <= 1'b0;
		end else if (np.page_sent) begin
			np.toggle <= ~np.toggle;
		end
	end

	// compliance bit forced off on gigabit pages, toggle inserted
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			np.tx_word <= anpr_pkg::NP_RESET;
		end else begin
			np.tx_word <= np.np_reg;
			np.tx_word[anpr_pkg::NP_TOGGLE] <= np.page_sent ? ~np.toggle : np.toggle;
			np.tx_word[anpr_pkg::NP_COMPLY] <= np.gig_mode ? 1'b0 :
				np.np_reg[anpr_pkg::NP_COMPLY];
		end
	end

	a_toggle_flip: assert property (@(posedge clk) disable iff (!rst_n)
		np.page_sent |=> np.toggle != $past(np.toggle))
		else $error("toggle did not flip");
	a_gig_comply: assert property (@(posedge clk) disable iff (!rst_n)
		np.gig_mode |=> !np.tx_word[anpr_pkg::NP_COMPLY])
		else $error("compliance bit sent on gigabit page");
endmodule // anpr_np_seq

/* anpr_regs.sv */
// negotiation partner ability, expansion and next-page register bank with Avalon slave
//
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/1ps
module anpr_regs (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] avs_address, // byte address
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic avs_readdatavalid,
	input wire logic base_page_valid, // pulse: new base page from partner
	input wire logic [15:0] base_page, // received base page word
	input wire logic next_page_valid, // pulse: new next page from partner
	input wire logic partner_an_able, // partner negotiates at all
	input wire logic pd_fault, // pulse: parallel detection fault
	input wire logic page_sent, // pulse: remote accepted outgoing page
	input wire logic gig_mode, // pages are 1000BASE-T next pages
	output logic [15:0] np_tx_word, // next page handed to the engine
	output logic store_in_lp_np, // next pages go to received-next-page register
	output logic irq
);
	anpr_np_if np_bus ();
	logic [15:0] partner; // partner ability contents
	logic [1:0] loc; // location able, location
	logic pd_latch; // latched parallel fault
	logic rx_latch; // latched page received
	logic lp_an; // partner negotiation capability
	logic [15:0] np_reg; // writable outgoing fields
	logic [anpr_pkg::IRQ_W-1:0] irq_status;
	logic [anpr_pkg::IRQ_W-1:0] irq_mask;
	logic rd_pending; // one cycle wait before a read answers
	logic [15:0] expansion_view;
	logic [15:0] np_view;
	logic wr_lo;
	logic next_pd;
	logic next_rx;

	// decode helper: address hits the given 16-bit register
	// halfword decode keeps 0x0c and 0x0e apart; a word decode would alias them
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a[7:1] == off[7:1]);
	endfunction

	anpr_np_seq u_seq (
		.clk(clk),
		.rst_n(rst_n),
		.np(np_bus)
	);
	assign np_bus.page_sent = page_sent;
	assign np_bus.gig_mode = gig_mode;
	assign np_bus.np_reg = np_reg;
	assign np_tx_word = np_bus.tx_word;

	// write commit: low byte lanes carry the 16-bit registers
	assign wr_lo = avs_write && !avs_waitrequest;

	// partner base page capture; read-only to software
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			partner <= anpr_pkg::PARTNER_RESET;
			lp_an <= 1'b0;
		end else begin
			lp_an <= partner_an_able;
			if (base_page_valid) begin
				// whole word kept, the reserved bit masked
				partner <= base_page & 16'hefff;
			end
		end
	end

	// expansion view: reserved upper bits read zero
	always_comb begin
		expansion_view = 16'h0000;
		expansion_view[anpr_pkg::EX_LOC_ABLE] = loc[1];
		expansion_view[anpr_pkg::EX_LOC] = loc[0];
		expansion_view[anpr_pkg::EX_PD_FAULT] = pd_latch;
		expansion_view[anpr_pkg::EX_LP_NP] = partner[anpr_pkg::PA_NEXT_PAGE];
		expansion_view[anpr_pkg::EX_NP_CAPABLE] = 1'b1;
		expansion_view[anpr_pkg::EX_PAGE_RX] = rx_latch;
		expansion_view[anpr_pkg::EX_LP_AN] = lp_an;
	end

	// next page store location steering: bit 5 counts only when bit 6 is set
	assign store_in_lp_np = loc[1] ? loc[0] : 1'b1;

	// location bits, writable
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			loc <= anpr_pkg::EX_LOC_RESET;
		end else if (wr_lo && hit(avs_address, anpr_pkg::OFF_EXPANSION) && avs_byteenable[0]) begin
			loc <= avs_writedata[anpr_pkg::EX_LOC_ABLE:anpr_pkg::EX_LOC];
		end
	end

	// latched-high flags clear at the edge that captures the read data
	// clearing there, not a cycle later, means an event in that cycle is never lost
	always_comb begin
		next_pd = pd_latch;
		next_rx = rx_latch;
		if (avs_read && !rd_pending && hit(avs_address, anpr_pkg::OFF_EXPANSION)) begin
			next_pd = 1'b0;
			next_rx = 1'b0;
		end
		if (pd_fault) begin
			next_pd = 1'b1;
		end
		if (base_page_valid || next_page_valid) begin
			next_rx = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pd_latch <= 1'b0;
			rx_latch <= 1'b0;
		end else begin
			pd_latch <= next_pd;
			rx_latch <= next_rx;
		end
	end

	// outgoing next page fields; bits 14 and 11 are not stored here
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			np_reg <= anpr_pkg::NP_RESET;
		end else if (wr_lo && hit(avs_address, anpr_pkg::OFF_NEXT_PAGE)) begin
			if (avs_byteenable[0]) begin
				np_reg[7:0] <= avs_writedata[7:0];
			end
			if (avs_byteenable[1]) begin
				np_reg[anpr_pkg::NP_MORE] <= avs_writedata[anpr_pkg::NP_MORE];
				np_reg[anpr_pkg::NP_MSG_PAGE] <= avs_writedata[anpr_pkg::NP_MSG_PAGE];
				np_reg[anpr_pkg::NP_COMPLY] <= avs_writedata[anpr_pkg::NP_COMPLY];
				np_reg[anpr_pkg::NP_CODE_HI:8] <= avs_writedata[anpr_pkg::NP_CODE_HI:8];
			end
		end
	end

	// read view of outgoing page: reserved bit zero, toggle from sequencer
	always_comb begin
		np_view = np_reg;
		np_view[anpr_pkg::NP_RSVD] = 1'b0;
		np_view[anpr_pkg::NP_TOGGLE] = np_bus.toggle;
	end

	// interrupt status: write one to clear, the event wins over the clear
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irq_status <= '0;
		end else begin
			for (int i = 0; i < anpr_pkg::IRQ_W; i++) begin
				if (wr_lo && hit(avs_address, anpr_pkg::OFF_IRQ_STATUS) && avs_writedata[i]) begin
					irq_status[i] <= 1'b0;
				end
			end
			if (base_page_valid || next_page_valid) begin
				irq_status[anpr_pkg::IRQ_PAGE_RX] <= 1'b1;
			end
			if (pd_fault) begin
				irq_status[anpr_pkg::IRQ_PD_FAULT] <= 1'b1;
			end
		end
	end

	// interrupt mask
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irq_mask <= anpr_pkg::IRQ_MASK_RESET;
		end else if (wr_lo && hit(avs_address, anpr_pkg::OFF_IRQ_MASK)) begin
			irq_mask <= avs_writedata[anpr_pkg::IRQ_W-1:0];
		end
	end

	assign irq = |(irq_status & irq_mask);

	// waitrequest: writes take one cycle, reads wait one cycle for data
	assign avs_waitrequest = avs_read && !rd_pending;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rd_pending <= 1'b0;
		end else begin
			rd_pending <= avs_read && !rd_pending;
		end
	end

	// read mux; unmapped addresses read zero
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			avs_readdata <= 32'h0000_0000;
			avs_readdatavalid <= 1'b0;
		end else begin
			avs_readdatavalid <= avs_read && !rd_pending;
			if (avs_read && !rd_pending) begin
				if (hit(avs_address, anpr_pkg::OFF_PARTNER)) begin
					avs_readdata <= {16'h0000, partner};
				end else if (hit(avs_address, anpr_pkg::OFF_EXPANSION)) begin
					avs_readdata <= {16'h0000, expansion_view};
				end else if (hit(avs_address, anpr_pkg::OFF_NEXT_PAGE)) begin
					avs_readdata <= {16'h0000, np_view};
				end else if (hit(avs_address, anpr_pkg::OFF_IRQ_STATUS)) begin
					avs_readdata <= {30'h0000_0000, irq_status};
				end else if (hit(avs_address, anpr_pkg::OFF_IRQ_MASK)) begin
					avs_readdata <= {30'h0000_0000, irq_mask};
				end else begin
					avs_readdata <= 32'h0000_0000;
				end
			end
		end
	end

	sequence s_page_in;
		base_page_valid ##1 1'b1;
	endsequence
	a_partner_cap: assert property (@(posedge clk) disable iff (!rst_n)
		base_page_valid |=> partner == ($past(base_page) & 16'hefff))
		else $error("partner page not captured");
	a_partner_hold: assert property (@(posedge clk) disable iff (!rst_n)
		!base_page_valid |=> $stable(partner))
		else $error("partner changed without page");
	a_pd_latch: assert property (@(posedge clk) disable iff (!rst_n)
		pd_fault |=> pd_latch)
		else $error("parallel fault not latched");
	a_rx_latch: assert property (@(posedge clk) disable iff (!rst_n)
		s_page_in |-> rx_latch)
		else $error("page received not latched");
	a_np_const: assert property (@(posedge clk) disable iff (!rst_n)
		expansion_view[anpr_pkg::EX_NP_CAPABLE])
		else $error("next page capable not one");
	a_lp_np_bit: assert property (@(posedge clk) disable iff (!rst_n)
		expansion_view[anpr_pkg::EX_LP_NP] == partner[anpr_pkg::PA_NEXT_PAGE])
		else $error("partner next page bit wrong");
	a_np_rsvd: assert property (@(posedge clk) disable iff (!rst_n)
		!np_view[anpr_pkg::NP_RSVD])
		else $error("reserved bit set");
	a_loc_steer: assert property (@(posedge clk) disable iff (!rst_n)
		!loc[1] |-> store_in_lp_np)
		else $error("location bit used while disabled");
	a_tx_body: assert property (@(posedge clk) disable iff (!rst_n)
		1'b1 |=> np_tx_word[10:0] == $past(np_reg[10:0]))
		else $error("outgoing word mismatch");
endmodule // anpr_regs

/* anpr_link_partner.sv */
// behavioural negotiation engine and remote partner driving the bank's event inputs
`timescale 1ns/1ps
module anpr_link_partner (
	input wire logic clk,
	output logic base_page_valid,
	output logic [15:0] base_page,
	output logic next_page_valid,
	output logic partner_an_able,
	output logic pd_fault,
	output logic page_sent,
	output logic gig_mode
);
	// strobes idle low; the word outside its strobe shows the inverse of the last value
	// idle levels, driven once by the bench before reset is released
	task automatic idle();
		{base_page_valid, next_page_valid, pd_fault, page_sent} <= 4'h0;
		{partner_an_able, gig_mode} <= 2'h0;
		base_page <= 16'h0000;
	endtask
	// a received base page: one-cycle strobe with its word, stale word never left behind
	task automatic send_base(input logic [15:0] w);
		@(posedge clk);
		base_page <= w;
		base_page_valid <= 1'b1;
		@(posedge clk);
		base_page <= ~w;
		base_page_valid <= 1'b0;
	endtask
	// one-cycle event: 0 next page in, 1 parallel fault, 2 our page taken
	task automatic pulse(input int k);
		@(posedge clk);
		next_page_valid <= (k == 0);
		pd_fault <= (k == 1);
		page_sent <= (k == 2);
		@(posedge clk);
		{next_page_valid, pd_fault, page_sent} <= 3'h0;
	endtask
	// level settings of the far side
	task automatic levels(input logic an, input logic gig);
		@(posedge clk);
		partner_an_able <= an;
		gig_mode <= gig;
	endtask
endmodule // anpr_link_partner

/* testbench.sv */
// self-checking bench for the negotiation register bank
`timescale 1ns/1ps
module testbench;
	// short local names for the bank's offsets
	localparam logic [7:0] PA = anpr_pkg::OFF_PARTNER;
	localparam logic [7:0] EX = anpr_pkg::OFF_EXPANSION;
	localparam logic [7:0] NP = anpr_pkg::OFF_NEXT_PAGE;
	localparam logic [7:0] IS = anpr_pkg::OFF_IRQ_STATUS;
	localparam logic [7:0] IM = anpr_pkg::OFF_IRQ_MASK;
	localparam logic [31:0] ALL = 32'hffff_ffff;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [3:0] avs_byteenable = 4'hf; // full lanes except while wr_be narrows them
	logic [31:0] avs_readdata;
	logic avs_waitrequest, avs_readdatavalid, base_page_valid, next_page_valid;
	logic [15:0] base_page, np_tx_word;
	logic partner_an_able, pd_fault, page_sent, gig_mode, store_in_lp_np, irq;
	int fails = 0;
	int compares = 0;
	// 200 MHz clock
	always #2.5 clk = ~clk;
	anpr_regs u_anpr_regs (.clk, .rst_n, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
		.avs_readdatavalid, .base_page_valid, .base_page, .next_page_valid,
		.partner_an_able, .pd_fault, .page_sent, .gig_mode, .np_tx_word,
		.store_in_lp_np, .irq);
	anpr_link_partner u_anpr_link_partner (.clk, .base_page_valid, .base_page,
		.next_page_valid, .partner_an_able, .pd_fault, .page_sent, .gig_mode);
	// the one compare: four-state equality so an unknown never matches
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("BAD at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// one Avalon transfer: held until waitrequest is sampled low, bounded wait
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0 && n < 20) begin
			@(posedge clk);
			n++;
		end
		if (n >= 20) chk(32'h0000_0000, 32'h0000_0001);
		q = avs_readdata;
		if (!wr) chk({31'h0, avs_readdatavalid}, 32'h0000_0001);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask
	// write on chosen byte lanes, then back to full lanes
	task automatic wr_be(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
		logic [31:0] q;
		avs_byteenable <= be;
		xfer(1'b1, a, d, q);
		avs_byteenable <= 4'hf;
	endtask
	// read and compare the bits under the mask
	task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] q;
		xfer(1'b0, a, 32'h0000_0000, q);
		chk(q & m, e);
	endtask
	// outgoing word is registered: let two edges land first
	task automatic npchk(input logic [15:0] e);
		repeat (2) @(posedge clk);
		chk({16'h0000, np_tx_word}, {16'h0000, e});
	endtask
	task automatic pinchk(input logic v, input logic e);
		@(posedge clk);
		chk({31'h0, v}, {31'h0, e});
	endtask
	// reset values and an unmapped place
	task automatic t_reset();
		rchk(PA, ALL, 32'h0000_0000);
		rchk(EX, ALL, 32'h0000_0064);
		rchk(8'h40, ALL, 32'h0000_0000);
		rchk(IM, ALL, 32'h0000_0000);
		rchk(NP, ALL, 32'h0000_2001);
		npchk(16'h2001);
		pinchk(store_in_lp_np, 1'b1);
		pinchk(irq, 1'b0);
		$display("test reset done");
	endtask
	// base page fields land in their bits, writes to the read-only word ignored
	task automatic t_partner();
		u_anpr_link_partner.levels(1'b1, 1'b0);
		u_anpr_link_partner.send_base(16'hffff);
		rchk(PA, ALL, 32'h0000_efff);
		wr(PA, 32'h0000_0000);
		rchk(PA, ALL, 32'h0000_efff);
		rchk(EX, 32'h0000_0009, 32'h0000_0009);
		u_anpr_link_partner.send_base(16'h2a15);
		rchk(PA, ALL, 32'h0000_2a15);
		rchk(EX, 32'h0000_0009, 32'h0000_0001);
		$display("test partner done");
	endtask
	// latched flags, sticky status, mask and interrupt level
	task automatic t_events();
		wr(IS, 32'h0000_0003);
		rchk(EX, 32'h0000_0012, 32'h0000_0000);
		u_anpr_link_partner.pulse(1);
		rchk(EX, 32'h0000_0012, 32'h0000_0010);
		rchk(EX, 32'h0000_0012, 32'h0000_0000);
		rchk(IS, ALL, 32'h0000_0002);
		pinchk(irq, 1'b0);
		wr(IM, 32'h0000_0002);
		pinchk(irq, 1'b1);
		wr(IS, 32'h0000_0002);
		pinchk(irq, 1'b0);
		u_anpr_link_partner.pulse(0);
		rchk(EX, 32'h0000_0012, 32'h0000_0002);
		rchk(EX, 32'h0000_0012, 32'h0000_0000);
		rchk(IS, ALL, 32'h0000_0001);
		wr(IM, 32'h0000_0001);
		pinchk(irq, 1'b1);
		wr(IS, 32'h0000_0001);
		pinchk(irq, 1'b0);
		$display("test events done");
	endtask
	// store location bits and read-only expansion bits
	task automatic t_location();
		wr(EX, 32'h0000_ffdf);
		rchk(EX, 32'h0000_ff64, 32'h0000_0044);
		pinchk(store_in_lp_np, 1'b0);
		wr(EX, 32'h0000_0020);
		rchk(EX, 32'h0000_0060, 32'h0000_0020);
		pinchk(store_in_lp_np, 1'b1);
		wr(EX, 32'h0000_0060);
		pinchk(store_in_lp_np, 1'b1);
		$display("test location done");
	endtask
	// outgoing page contents, compliance on gigabit pages and toggle per page
	task automatic t_next();
		wr(NP, 32'h0000_ffff);
		npchk(16'hb7ff);
		rchk(NP, ALL, 32'h0000_b7ff);
		u_anpr_link_partner.levels(1'b1, 1'b1);
		npchk(16'ha7ff);
		u_anpr_link_partner.pulse(2);
		npchk(16'hafff);
		u_anpr_link_partner.pulse(2);
		npchk(16'ha7ff);
		u_anpr_link_partner.levels(1'b1, 1'b0);
		wr(NP, 32'h0000_0800);
		npchk(16'h0000);
		rchk(NP, ALL, 32'h0000_0000);
		u_anpr_link_partner.pulse(2);
		npchk(16'h0800);
		rchk(NP, ALL, 32'h0000_0800);
		wr_be(NP, 32'h0000_ffff, 4'h1);
		rchk(NP, ALL, 32'h0000_08ff);
		wr_be(NP, 32'h0000_ff00, 4'h2);
		rchk(NP, ALL, 32'h0000_bfff);
		wr_be(EX, 32'h0000_0000, 4'h2);
		rchk(EX, 32'h0000_0060, 32'h0000_0060);
		$display("test next page done");
	endtask
	task automatic final_report();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// watchdog: the tests need under 200 cycles, this allows 10000
	initial begin
		#50000;
		fails++;
		$display("BAD at %0t got %h expected %h", $time, 32'h0, 32'h1);
		final_report();
	end
	// main sequence
	initial begin
		u_anpr_link_partner.idle();
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_reset();
		t_partner();
		t_events();
		t_location();
		t_next();
		final_report();
	end
endmodule // testbench
